// [ckrc_pkg.sv]
//==============================================================================
// Clock, reset and transmit power-down control: shared constants
//==============================================================================
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: 100 MHz core clock, registers reached over AXI4-Lite
// Notes:   Printed register numbers are indices; byte address is four times
//
// Overview of operation
// - DAC sample clock is oscillator input frequency times the PLL multiplier.
// - Master clock is the DAC sample clock divided by four.
// - Divider values 2 to 63 give master clock over divider on aux pin.
// - Divider zero, the default, puts a buffered oscillator clock on aux pin.
// - A setting picks oscillator or PLL-derived clock for ADC sampling.
// - Host holds reset low until power stable; writes accepted only after.
// - During reset all internal clocks stop except the aux clock output.
// - Reset release restarts the PLL multiplier and restores register defaults.
// - Soft reset bit acts as hardware reset but spares register zero.
// - Power-down low stops transmit clocks, resets CIC; release restarts them.
// - CIC stays in reset 80 master clocks after power-down release.
// - Software power-down bit acts like the pin, effective at write end.

package ckrc_pkg;

  //============================================================================
  // Register indices (byte address = index * 4)
  //============================================================================
  localparam logic [5:0] IDX_CTRL0  = 6'h00;
  localparam logic [5:0] IDX_REFDIV = 6'h01;
  localparam logic [5:0] IDX_PWR    = 6'h02;
  localparam logic [5:0] IDX_ADCCLK = 6'h08;
  localparam logic [5:0] IDX_PLLMUL = 6'h10;
  localparam logic [5:0] IDX_STATUS = 6'h11;

  //============================================================================
  // Field positions
  //============================================================================
  localparam int BIT_SOFT_RST = 5;
  localparam int BIT_TX_PD    = 5;
  localparam int BIT_ADC_OSC  = 0;
  localparam int ST_SETTLED   = 0;
  localparam int ST_IN_RESET  = 1;
  localparam int ST_CIC_RST   = 2;
  localparam int ST_TX_RUN    = 3;

  //============================================================================
  // Reset values
  //============================================================================
  localparam logic [7:0] CTRL0_RST  = 8'h00;
  localparam logic [5:0] REFDIV_RST = 6'h00;
  localparam logic [7:0] PWR_RST    = 8'h00;
  localparam logic [7:0] ADCCLK_RST = 8'h00;
  localparam logic [5:0] PLLMUL_RST = 6'h04;

  //============================================================================
  // Divides and timing
  //============================================================================
  localparam logic [5:0] MCLK_DIV      = 6'h04;
  localparam logic [5:0] REFDIV_MIN    = 6'h02;
  localparam int         CIC_W         = 7;
  localparam int         CIC_HOLD_MCLK = 80;
  localparam logic [3:0] SOFT_RST_CYC  = 4'h4;
  localparam int         CLK_PERIOD_NS = 10;
  localparam int         PLL_SETTLE_NS = 1000000;
  localparam int         PLL_SETTLE_CYC = PLL_SETTLE_NS / CLK_PERIOD_NS;

  //============================================================================
  // AXI responses
  //============================================================================
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// [ckrc_div.sv]
//==============================================================================
// Edge-counting clock divider
//==============================================================================
// Purpose: Divides a stream of source rising-edge pulses by a programmable N
// Assumes: Source pulses no closer than every other core clock
// Notes:   Output is high for the first half of each period
`timescale 1ns/100ps

module ckrc_div #(
  parameter int W = 6
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Control
  input  wire logic         run,
  input  wire logic         in_rise,
  input  wire logic [W-1:0] divisor,
  // Divided clock
  output logic              clk_out,
  output logic              rise
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  if (W < 3) begin : g_chk
    $error("ckrc_div: W too small");
  end

  assign next_cnt = cnt + 1'b1;

  // Counting source edges keeps the output phase-locked to the source
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      cnt     <= '0;
      clk_out <= 1'b0;
      rise    <= 1'b0;
    end else begin
      rise <= 1'b0;
      if (in_rise) begin
        if (cnt >= divisor - 1'b1) begin
          cnt     <= '0;
          clk_out <= 1'b1;
          rise    <= 1'b1;
        end else begin
          cnt     <= next_cnt;
          // Only a wrap raises the output, so no stray half-period after reset
          clk_out <= clk_out && (next_cnt < (divisor >> 1));
        end
      end
    end
  end

  div_wrap_a: assert property (@(posedge clk) disable iff (srst)
    $rose(clk_out) |-> $past(in_rise) && $past(cnt) >= $past(divisor) - 1'b1)
    else $error("divided clock rose away from a count wrap");

endmodule

// [ckrc_top.sv]
//==============================================================================
// Clock, reset and transmit power-down control
//==============================================================================
// Purpose: Sample, master, aux and ADC clocks; reset and Tx power-down logic
// Assumes: Core clock well above the modelled DAC sample clock rate
// Notes:   Clocks are synthesised as levels from the core clock
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps

module ckrc_top #(
  parameter int MUL_W          = 6,
  parameter int PER_W          = 16,
  parameter int PLL_SETTLE_CYC = ckrc_pkg::PLL_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Device pins in
  input  wire logic        osc_input_clock,
  input  wire logic        reset_n,
  input  wire logic        tx_powerdown_n,
  // Generated clocks and transmit controls
  output logic             dac_sample_clock,
  output logic             aux_clock_out,
  output logic             adc_sample_clock,
  output logic             master_clock,
  output logic             tx_clock_en,
  output logic             cic_filter_reset,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int SW = $clog2(PLL_SETTLE_CYC + 1);

  if (MUL_W < 2 || MUL_W > 6 || PER_W < 8) begin : g_chk
    $error("ckrc_top: unsupported MUL_W or PER_W");
  end

  //============================================================================
  // Pin synchronisers: filtered value moves when stages two and three agree
  //============================================================================
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] pin_f;
  logic       osc_f;
  logic       pin_rst;
  logic       txpd_pin;

  always_ff @(posedge clk) begin
    if (srst) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sync3 <= 3'h0;
      pin_f <= 3'h0;
    end else begin
      sync1 <= {tx_powerdown_n, reset_n, osc_input_clock};
      sync2 <= sync1;
      sync3 <= sync2;
      pin_f <= (sync2 & sync3) | (pin_f & (sync2 ^ sync3));
    end
  end

  assign osc_f    = pin_f[0];
  assign pin_rst  = !pin_f[1];
  assign txpd_pin = !pin_f[2];

  //============================================================================
  // Registers
  //============================================================================
  logic [7:0]       ctrl0;
  logic [5:0]       refdiv;
  logic [7:0]       pwr;
  logic [7:0]       adcclk;
  logic [MUL_W-1:0] pll_mul;
  logic [3:0]       soft_cnt;
  logic             soft_act;
  logic             core_rst;
  logic             do_wr;
  logic             wr_ok;
  logic [5:0]       wr_idx;
  logic [7:0]       wr_byte;
  logic             soft_wr;

  assign soft_act = soft_cnt != 4'h0;
  assign core_rst = pin_rst || soft_act;
  assign soft_wr  = do_wr && wr_ok && wr_idx == ckrc_pkg::IDX_CTRL0
                    && wr_byte[ckrc_pkg::BIT_SOFT_RST];

  // Soft reset runs a fixed count and then drops its bit
  always_ff @(posedge clk) begin
    if (srst || pin_rst) begin
      soft_cnt <= 4'h0;
    end else if (soft_wr) begin
      soft_cnt <= ckrc_pkg::SOFT_RST_CYC;
    end else if (soft_act) begin
      soft_cnt <= soft_cnt - 1'b1;
    end
  end

  // Pin reset holds defaults through release; soft reset spares ctrl0
  always_ff @(posedge clk) begin
    if (srst || pin_rst) begin
      ctrl0   <= ckrc_pkg::CTRL0_RST;
      refdiv  <= ckrc_pkg::REFDIV_RST;
      pwr     <= ckrc_pkg::PWR_RST;
      adcclk  <= ckrc_pkg::ADCCLK_RST;
      pll_mul <= MUL_W'(ckrc_pkg::PLLMUL_RST);
    end else if (soft_act) begin
      refdiv  <= ckrc_pkg::REFDIV_RST;
      pwr     <= ckrc_pkg::PWR_RST;
      adcclk  <= ckrc_pkg::ADCCLK_RST;
      pll_mul <= MUL_W'(ckrc_pkg::PLLMUL_RST);
    end else if (do_wr && wr_ok) begin
      case (wr_idx)
        ckrc_pkg::IDX_CTRL0:  ctrl0   <= wr_byte;
        ckrc_pkg::IDX_REFDIV: refdiv  <= wr_byte[5:0];
        ckrc_pkg::IDX_PWR:    pwr     <= wr_byte;
        ckrc_pkg::IDX_ADCCLK: adcclk  <= wr_byte;
        ckrc_pkg::IDX_PLLMUL: pll_mul <= wr_byte[MUL_W-1:0];
        default:              ctrl0   <= ctrl0;
      endcase
    end
  end

  //============================================================================
  // PLL model: M output cycles per measured oscillator period
  //============================================================================
  // Limitation: 2*M must stay below the oscillator period in core clocks
  logic             osc_q;
  logic             osc_rise;
  logic [PER_W-1:0] per_cnt;
  logic [PER_W-1:0] period;
  logic [PER_W-1:0] acc;
  logic [PER_W:0]   acc_sum;
  logic             dac_tick;
  logic             dac_rise;

  assign osc_rise = osc_f && !osc_q;
  assign acc_sum  = {1'b0, acc} + (PER_W+1)'({pll_mul, 1'b0});
  assign dac_tick = acc_sum >= {1'b0, period};

  // Reset restarts the period measurement, i.e. the multiplier lock
  always_ff @(posedge clk) begin
    if (srst || core_rst) begin
      osc_q   <= 1'b0;
      per_cnt <= '0;
      period  <= '0;
    end else begin
      osc_q <= osc_f;
      if (osc_rise) begin
        period  <= per_cnt + 1'b1;
        per_cnt <= '0;
      end else if (per_cnt != '1) begin
        per_cnt <= per_cnt + 1'b1;
      end
    end
  end

  // Sample clock stops in reset
  always_ff @(posedge clk) begin
    if (srst || core_rst || period == '0) begin
      acc              <= '0;
      dac_sample_clock <= 1'b0;
      dac_rise         <= 1'b0;
    end else if (dac_tick) begin
      acc              <= PER_W'(acc_sum - {1'b0, period});
      dac_sample_clock <= !dac_sample_clock;
      dac_rise         <= !dac_sample_clock;
    end else begin
      acc      <= acc_sum[PER_W-1:0];
      dac_rise <= 1'b0;
    end
  end

  //============================================================================
  // Master and aux clocks
  //============================================================================
  logic mclk_rise;
  logic aux_div_out;
  logic aux_div_run;

  assign aux_div_run = refdiv >= ckrc_pkg::REFDIV_MIN;

  ckrc_div #(.W(6)) u_mclk_div (
    .clk     (clk),
    .srst    (srst),
    .run     (!core_rst),
    .in_rise (dac_rise),
    .divisor (ckrc_pkg::MCLK_DIV),
    .clk_out (master_clock),
    .rise    (mclk_rise)
  );

  ckrc_div #(.W(6)) u_aux_div (
    .clk     (clk),
    .srst    (srst),
    .run     (aux_div_run),
    .in_rise (mclk_rise),
    .divisor (refdiv),
    .clk_out (aux_div_out),
    .rise    ()
  );

  // Aux pin keeps running through reset, defaulting to the oscillator copy
  always_ff @(posedge clk) begin
    if (srst) begin
      aux_clock_out    <= 1'b0;
      adc_sample_clock <= 1'b0;
    end else begin
      aux_clock_out    <= aux_div_run ? aux_div_out : osc_f;
      adc_sample_clock <= adcclk[ckrc_pkg::BIT_ADC_OSC] ?
                          osc_f : master_clock;
    end
  end

  //============================================================================
  // PLL settle timer for status
  //============================================================================
  logic [MUL_W-1:0] mul_q;
  logic [SW-1:0]    settle_cnt;

  always_ff @(posedge clk) begin
    if (srst || core_rst || pll_mul != mul_q) begin
      mul_q      <= pll_mul;
      settle_cnt <= SW'(PLL_SETTLE_CYC);
    end else if (settle_cnt != '0) begin
      settle_cnt <= settle_cnt - 1'b1;
    end
  end

  //============================================================================
  // Transmit power-down and CIC flush
  //============================================================================
  logic                         tx_pd;
  logic [ckrc_pkg::CIC_W-1:0]   cic_cnt;

  assign tx_pd = txpd_pin || pwr[ckrc_pkg::BIT_TX_PD];

  // Count is held loaded while powered down and runs on master clock edges
  always_ff @(posedge clk) begin
    if (srst || core_rst || tx_pd) begin
      cic_cnt <= ckrc_pkg::CIC_W'(ckrc_pkg::CIC_HOLD_MCLK);
    // Counts only cycles with transmit clocks running
    end else if (mclk_rise && tx_clock_en && cic_cnt != '0) begin
      cic_cnt <= cic_cnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_clock_en      <= 1'b0;
      cic_filter_reset <= 1'b1;
    end else begin
      tx_clock_en      <= !tx_pd && !core_rst;
      cic_filter_reset <= tx_pd || core_rst || cic_cnt != '0;
    end
  end

  //============================================================================
  // AXI4-Lite slave
  //============================================================================
  logic       aw_got;
  logic       w_got;
  logic       aw_take;
  logic       w_take;
  logic       b_done;
  logic       wr_map;
  logic [7:0] aw_addr;
  logic [7:0] rd_byte;
  logic       rd_map;
  logic [5:0] rd_idx;
  logic [7:0] status;
  logic       s_axi_wstrb_q;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take  = s_axi_wvalid && s_axi_wready;
  assign b_done  = s_axi_bvalid && s_axi_bready;
  assign do_wr   = aw_got && w_got && !s_axi_bvalid;
  assign wr_idx  = aw_addr[7:2];
  assign wr_map  = aw_addr[1:0] == 2'h0 &&
                   (wr_idx == ckrc_pkg::IDX_CTRL0 ||
                    wr_idx == ckrc_pkg::IDX_REFDIV ||
                    wr_idx == ckrc_pkg::IDX_PWR ||
                    wr_idx == ckrc_pkg::IDX_ADCCLK ||
                    wr_idx == ckrc_pkg::IDX_PLLMUL);
  // Writes are refused while any reset is active
  assign wr_ok   = wr_map && !core_rst && s_axi_wstrb_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      wr_byte       <= 8'h00;
      s_axi_wstrb_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ckrc_pkg::RESP_OKAY;
    end else begin
      aw_got        <= (aw_got || aw_take) && !b_done;
      w_got         <= (w_got || w_take) && !b_done;
      s_axi_awready <= !((aw_got || aw_take) && !b_done);
      s_axi_wready  <= !((w_got || w_take) && !b_done);
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        wr_byte       <= s_axi_wdata[7:0];
        s_axi_wstrb_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? ckrc_pkg::RESP_OKAY : ckrc_pkg::RESP_SLVERR;
      end else if (b_done) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign rd_idx = s_axi_araddr[7:2];
  assign status = {4'h0, !tx_pd && !core_rst, cic_filter_reset, core_rst,
                   settle_cnt == '0};

  always_comb begin
    rd_byte = 8'h00;
    rd_map  = s_axi_araddr[1:0] == 2'h0;
    case (rd_idx)
      ckrc_pkg::IDX_CTRL0:  rd_byte = {ctrl0[7:6], soft_act, ctrl0[4:0]};
      ckrc_pkg::IDX_REFDIV: rd_byte = {2'h0, refdiv};
      ckrc_pkg::IDX_PWR:    rd_byte = pwr;
      ckrc_pkg::IDX_ADCCLK: rd_byte = adcclk;
      ckrc_pkg::IDX_PLLMUL: rd_byte = 8'(pll_mul);
      ckrc_pkg::IDX_STATUS: rd_byte = status;
      default:              rd_map  = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ckrc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h00_0000, rd_map ? rd_byte : 8'h00};
      s_axi_rresp   <= rd_map ? ckrc_pkg::RESP_OKAY : ckrc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  //============================================================================
  // Assertions
  //============================================================================
  localparam int SOFT_LO = 1;
  localparam int SOFT_HI = 8;

  sequence soft_wr_s;
    soft_wr;
  endsequence

  sequence pd_release_s;
    !tx_pd && $past(tx_pd) && !core_rst;
  endsequence

  pll_tick_a: assert property (@(posedge clk) disable iff (srst)
    (!core_rst && period != '0 && dac_tick) |=>
      dac_sample_clock != $past(dac_sample_clock))
    else $error("sample clock missed a PLL tick");

  aux_div_a: assert property (@(posedge clk) disable iff (srst)
    aux_div_run |=> aux_clock_out == $past(aux_div_out))
    else $error("aux pin not carrying divided master clock");

  aux_osc_a: assert property (@(posedge clk) disable iff (srst)
    refdiv == 6'h00 |=> aux_clock_out == $past(osc_f))
    else $error("aux pin not carrying oscillator copy");

  adc_sel_a: assert property (@(posedge clk) disable iff (srst)
    adcclk[ckrc_pkg::BIT_ADC_OSC] |=> adc_sample_clock == $past(osc_f))
    else $error("ADC clock not taken from oscillator");

  rst_stop_a: assert property (@(posedge clk) disable iff (srst)
    core_rst [*2] |=> !dac_sample_clock && !master_clock && !tx_clock_en)
    else $error("internal clock running during reset");

  pin_rst_a: assert property (@(posedge clk) disable iff (srst)
    pin_rst |=> refdiv == ckrc_pkg::REFDIV_RST && pwr == ckrc_pkg::PWR_RST
      && ctrl0 == ckrc_pkg::CTRL0_RST)
    else $error("registers not at default after pin reset");

  soft_keep_a: assert property (@(posedge clk) disable iff (srst)
    soft_wr_s ##1 (soft_act && !pin_rst) |=>
      refdiv == ckrc_pkg::REFDIV_RST && ctrl0 == $past(ctrl0))
    else $error("soft reset mishandled register zero or others");

  soft_clr_a: assert property (@(posedge clk) disable iff (srst)
    soft_wr_s ##1 !pin_rst |-> soft_act ##[SOFT_LO:SOFT_HI] !soft_act)
    else $error("soft reset bit did not clear itself");

  pd_stop_a: assert property (@(posedge clk) disable iff (srst)
    tx_pd |=> !tx_clock_en && cic_filter_reset)
    else $error("power-down did not stop transmit clocks");

  cic_hold_a: assert property (@(posedge clk) disable iff (srst)
    pd_release_s |-> cic_cnt == ckrc_pkg::CIC_W'(ckrc_pkg::CIC_HOLD_MCLK)
      ##1 cic_filter_reset)
    else $error("CIC flush hold not started at release");

  sw_pd_a: assert property (@(posedge clk) disable iff (srst)
    (do_wr && wr_ok && wr_idx == ckrc_pkg::IDX_PWR
      && wr_byte[ckrc_pkg::BIT_TX_PD]) |-> ##2 !tx_clock_en)
    else $error("software power-down not immediate");

  wr_rst_a: assert property (@(posedge clk) disable iff (srst)
    (do_wr && core_rst) |=> s_axi_bresp == ckrc_pkg::RESP_SLVERR)
    else $error("write accepted during reset");

endmodule

// [ckrc_osc.sv]
//==============================================================================
// Oscillator model for the host side
//==============================================================================
// Purpose: Free-running oscillator pin, phase unrelated to the core clock
// Assumes: Period above twice the multiplier in core clocks
// Notes:   A crystal never stops, so it runs through reset
`timescale 1ns/100ps

module ckrc_osc #(
  parameter int HALF_NS = 150
) (
  // Oscillator pin
  output logic osc_input_clock
);
  initial begin
    osc_input_clock = 1'b0;
    #7;
    forever #HALF_NS osc_input_clock = ~osc_input_clock;
  end
endmodule

// [clock_reset_tx_powerdown_control_test.sv]
//==============================================================================
// Bench for clock, reset and transmit power-down control
//==============================================================================
// Purpose: Register, pin and clock ratio checks
// Assumes: Oscillator period of 30 core clocks
// Notes:   Settle count shortened to keep the run brief
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((e) !== (s)) begin \
  err_count++; $display("[FAIL] %s exp %h got %h", n, e, s); end end

module clock_reset_tx_powerdown_control_test;
  localparam logic [33:0] ERR = {ckrc_pkg::RESP_SLVERR, 32'h0000_0000};
  logic clk = 0, srst = 1, reset_n = 0, tx_powerdown_n = 0, osc_input_clock;
  logic dac_sample_clock, aux_clock_out, adc_sample_clock, master_clock;
  logic tx_clock_en, cic_filter_reset, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, pd, pm, pa, pc, mr, dr;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [1:0]  s_axi_bresp, s_axi_rresp, bv, bq[$];
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, div;
  logic [31:0] s_axi_rdata, s_axi_wdata = '0;
  logic [33:0] ev, rq[$];
  int err_count = 0, total_checks = 0;
  int dc, mc, hc, dpm, mpa, held, mt, at, cyc, m0, a0;

  ckrc_top #(.PLL_SETTLE_CYC(50)) u_dut (.*);
  ckrc_osc u_osc (.*);

  initial forever #5 clk = ~clk;
  assign mr = master_clock & ~pm;
  assign dr = dac_sample_clock & ~pd;

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, d, input logic [1:0] r);
    @(posedge clk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    fork
      begin @(posedge clk iff s_axi_awready); s_axi_awvalid <= 1'b0; end
      begin @(posedge clk iff s_axi_wready); s_axi_wvalid <= 1'b0; end
    join
    @(posedge clk iff s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clk);
    rq.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk iff s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clk iff s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  task automatic close_out();
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Rise counters: ratios are measured, never taken from the design
  always @(posedge clk) begin
    pd <= dac_sample_clock;
    pm <= master_clock;
    pa <= aux_clock_out;
    pc <= cic_filter_reset;
    dc <= mr ? 0 : dc + dr;
    if (mr) dpm <= dc + dr;
    mc <= (aux_clock_out & ~pa) ? 0 : mc + mr;
    if (aux_clock_out & ~pa) mpa <= mc + mr;
    at <= at + (aux_clock_out & ~pa);
    mt <= mt + mr;
    hc <= (cic_filter_reset & tx_clock_en) ? hc + mr : 0;
    if (pc & ~cic_filter_reset) held <= hc;
    if (s_axi_rvalid & s_axi_rready) begin
      ev = rq.pop_front();
      `CHK("read", ev, {s_axi_rresp, s_axi_rdata})
    end
    if (s_axi_bvalid & s_axi_bready) begin
      bv = bq.pop_front();
      `CHK("bresp", bv, s_axi_bresp)
    end
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'he48f_4648));
    div = 8'h02 + 8'($urandom % 6);
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    reset_n <= 1'b1;
    wt(400);
    rd(8'h44, 34'h5);
    rd(8'h04, '0);
    rd(8'h40, 34'h4);
    rd(8'h0c, ERR);
    wr(8'h44, 8'h01, 2'h2);
    wt(1);
    `CHK("dac per mclk", 4, dpm)
    `CHK("mclk per aux", 1, mpa)
    wr(8'h40, 8'h08, 2'h0);
    wr(8'h20, 8'h01, 2'h0);
    rd(8'h20, 34'h1);
    wr(8'h20, 8'h00, 2'h0);
    wt(400);
    `CHK("mclk per osc", 2, mpa)
    wr(8'h04, div, 2'h0);
    rd(8'h04, {26'h000_0000, div});
    wt(900);
    `CHK("mclk per aux", div, 8'(mpa))
    `CHK("tx off", 1'b0, tx_clock_en)
    `CHK("cic on", 1'b1, cic_filter_reset)
    @(posedge clk);
    tx_powerdown_n <= 1'b1;
    wt(1500);
    `CHK("cic hold", 80, held)
    `CHK("tx on", 1'b1, tx_clock_en)
    wr(8'h08, 8'h20, 2'h0);
    wt(3);
    `CHK("sw tx off", 1'b0, tx_clock_en)
    wr(8'h08, 8'h00, 2'h0);
    wt(1500);
    `CHK("sw cic hold", 80, held)
    wr(8'h00, 8'h20, 2'h0);
    wt(8);
    rd(8'h00, '0);
    rd(8'h04, '0);
    rd(8'h40, 34'h4);
    wr(8'h04, 8'h03, 2'h0);
    @(posedge clk);
    reset_n <= 1'b0;
    wt(10);
    m0 = mt;
    a0 = at;
    wr(8'h04, 8'h05, 2'h2);
    wt(300);
    `CHK("mclk stops", m0, mt)
    `CHK("aux runs", 1'b1, at > a0)
    @(posedge clk);
    reset_n <= 1'b1;
    wt(20);
    rd(8'h04, '0);
    rd(8'h40, 34'h4);
    wt(20);
    close_out();
  end
endmodule
